// [core/mfp_pkg.sv]
// Constants and register selects for the multi-function I/O port block
package mfp_pkg;

  localparam int unsigned MFP_DW   = 8;
  localparam int unsigned MFP_I2CW = 5;
  localparam int unsigned MFP_SELW = 4;

  // Register selects on the CPU port
  localparam logic [MFP_SELW-1:0] SEL_HC_LATCH   = 4'h0;
  localparam logic [MFP_SELW-1:0] SEL_HC_PIN     = 4'h1;
  localparam logic [MFP_SELW-1:0] SEL_SER_LATCH  = 4'h2;
  localparam logic [MFP_SELW-1:0] SEL_SER_DRIVE  = 4'h3;
  localparam logic [MFP_SELW-1:0] SEL_SER_PIN    = 4'h4;
  localparam logic [MFP_SELW-1:0] SEL_I2C_LATCH  = 4'h5;
  localparam logic [MFP_SELW-1:0] SEL_I2C_PIN    = 4'h6;
  localparam logic [MFP_SELW-1:0] SEL_WAKE_DATA  = 4'h7;
  localparam logic [MFP_SELW-1:0] SEL_WAKE_DIR   = 4'h8;
  localparam logic [MFP_SELW-1:0] SEL_WAKE_IEN   = 4'h9;
  localparam logic [MFP_SELW-1:0] SEL_WAKE_KEY   = 4'ha;
  localparam logic [MFP_SELW-1:0] SEL_ANA_DATA   = 4'hb;
  localparam logic [MFP_SELW-1:0] SEL_ANA_DIR    = 4'hc;
  localparam logic [MFP_SELW-1:0] SEL_ANA_IEN    = 4'hd;

  // Reset values
  localparam logic [MFP_DW-1:0]   HC_LATCH_RST   = 8'hff;
  localparam logic [MFP_DW-1:0]   SER_LATCH_RST  = 8'hff;
  localparam logic [MFP_DW-1:0]   SER_DRIVE_RST  = 8'h00;
  localparam logic [MFP_I2CW-1:0] I2C_LATCH_RST  = 5'h1f;
  localparam logic [MFP_DW-1:0]   DIR_RST        = 8'h00;
  localparam logic [MFP_DW-1:0]   DATA_RST       = 8'h00;
  localparam logic [MFP_DW-1:0]   IEN_RST        = 8'hff;
  localparam logic [MFP_DW-1:0]   KEY_SEL_RST    = 8'h00;
  localparam logic [MFP_DW-1:0]   RDATA_RST      = 8'h00;
  localparam logic [MFP_DW-1:0]   UPPER_ZERO     = 8'h00;

endpackage : mfp_pkg

// [core/mfp_port_if.sv]
// Interface between the top and a direction-controlled port slice
`timescale 1ns/1ps
interface mfp_port_if #(parameter int unsigned W = 8);
  logic         wr_data_stb;
  logic         wr_dir_stb;
  logic         wr_ien_stb;
  logic [W-1:0] wr_val;
  logic [W-1:0] rd_val;
  logic [W-1:0] dir;
  logic [W-1:0] ien;
  logic [W-1:0] pin_in;
  logic [W-1:0] pin_out;
  logic [W-1:0] pin_oe;

  modport ctrl (output wr_data_stb, output wr_dir_stb, output wr_ien_stb, output wr_val,
                output pin_in, input rd_val, input dir, input ien, input pin_out, input pin_oe);
  modport port (input wr_data_stb, input wr_dir_stb, input wr_ien_stb, input wr_val,
                input pin_in, output rd_val, output dir, output ien, output pin_out, output pin_oe);
endinterface : mfp_port_if

// [core/mfp_dir_port.sv]
// Direction and input-enable controlled port slice
`timescale 1ns/1ps
module mfp_dir_port
  import mfp_pkg::*;
#(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Control and pin side
  mfp_port_if.port  bus
);

  logic [W-1:0] dir_ff,  nxt_dir;
  logic [W-1:0] ien_ff,  nxt_ien;
  logic [W-1:0] data_ff, nxt_data;
  logic [W-1:0] out_ff,  nxt_out;
  logic [W-1:0] oe_ff,   nxt_oe;

  // Per-bit read value: latch, pin or zero
  function automatic logic read_bit(input logic d, input logic e, input logic l, input logic p);
    read_bit = d ? l : (e ? p : 1'b0);
  endfunction : read_bit

  ////////////////////////////////////////////////////////////////////////////
  // Next state of control registers and pin drivers
  always_comb begin
    nxt_dir  = bus.wr_dir_stb  ? bus.wr_val : dir_ff;
    nxt_ien  = bus.wr_ien_stb  ? bus.wr_val : ien_ff;
    nxt_data = bus.wr_data_stb ? bus.wr_val : data_ff;
    nxt_out  = nxt_data;
    nxt_oe   = nxt_dir;
  end

  // Register update, reset forces initial state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dir_ff  <= W'(DIR_RST);
      ien_ff  <= W'(IEN_RST);
      data_ff <= W'(DATA_RST);
      out_ff  <= W'(DATA_RST);
      oe_ff   <= W'(DIR_RST);
    end else begin
      dir_ff  <= nxt_dir;
      ien_ff  <= nxt_ien;
      data_ff <= nxt_data;
      out_ff  <= nxt_out;
      oe_ff   <= nxt_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux per bit
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_rd
      assign bus.rd_val[gi] = read_bit(dir_ff[gi], ien_ff[gi], data_ff[gi], bus.pin_in[gi]);
    end
  endgenerate

  // Outputs to the top
  assign bus.dir     = dir_ff;
  assign bus.ien     = ien_ff;
  assign bus.pin_out = out_ff;
  assign bus.pin_oe  = oe_ff;

endmodule : mfp_dir_port

// [core/mfp_io_ports.sv]
// Top of the multi-function I/O port block
`timescale 1ns/1ps
module mfp_io_ports
  import mfp_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // CPU register port
  input  wire logic                cpu_wr,
  input  wire logic                cpu_rd,
  input  wire logic [MFP_SELW-1:0] cpu_sel,
  input  wire logic [MFP_DW-1:0]   cpu_wdata,
  output logic      [MFP_DW-1:0]   cpu_rdata,
  // High-current port pins
  input  wire logic [MFP_DW-1:0]   hc_pin_in,
  output logic      [MFP_DW-1:0]   hc_pin_out,
  output logic      [MFP_DW-1:0]   hc_pin_oe,
  // Serial-shared port pins
  input  wire logic [MFP_DW-1:0]   ser_pin_in,
  output logic      [MFP_DW-1:0]   ser_pin_out,
  output logic      [MFP_DW-1:0]   ser_pin_oe,
  // I2C-shared port pins
  input  wire logic [MFP_I2CW-1:0] i2c_pin_in,
  output logic      [MFP_I2CW-1:0] i2c_pin_out,
  output logic      [MFP_I2CW-1:0] i2c_pin_oe,
  // Wakeup-capable port pins and wakeup enables
  input  wire logic [MFP_DW-1:0]   wake_pin_in,
  output logic      [MFP_DW-1:0]   wake_pin_out,
  output logic      [MFP_DW-1:0]   wake_pin_oe,
  output logic      [MFP_DW-1:0]   wake_digital_en,
  output logic      [MFP_DW-1:0]   key_wakeup_select,
  // Analog-only port pins
  input  wire logic [MFP_DW-1:0]   ana_pin_in,
  output logic      [MFP_DW-1:0]   ana_pin_out,
  output logic      [MFP_DW-1:0]   ana_pin_oe,
  output logic      [MFP_DW-1:0]   ana_digital_en
);

  mfp_port_if #(.W(MFP_DW)) wake_if ();
  mfp_port_if #(.W(MFP_DW)) ana_if ();

  logic [MFP_DW-1:0]   hc_port_a_latch_ff,         nxt_hc_port_a_latch;
  logic [MFP_DW-1:0]   serial_port_latch_ff,       nxt_serial_port_latch;
  logic [MFP_DW-1:0]   serial_port_drive_select_ff, nxt_serial_port_drive_select;
  logic [MFP_I2CW-1:0] i2c_port_latch_ff,          nxt_i2c_port_latch;
  logic [MFP_DW-1:0]   key_sel_ff,                 nxt_key_sel;
  logic [MFP_DW-1:0]   hc_out_ff,                  nxt_hc_out;
  logic [MFP_DW-1:0]   hc_oe_ff,                   nxt_hc_oe;
  logic [MFP_DW-1:0]   ser_out_ff,                 nxt_ser_out;
  logic [MFP_DW-1:0]   ser_oe_ff,                  nxt_ser_oe;
  logic [MFP_I2CW-1:0] i2c_out_ff,                 nxt_i2c_out;
  logic [MFP_I2CW-1:0] i2c_oe_ff,                  nxt_i2c_oe;
  logic [MFP_DW-1:0]   rdata_ff,                   nxt_rdata;

  // Write strobe for a given register select
  function automatic logic wr_hit(input logic wr, input logic [MFP_SELW-1:0] sel,
                                  input logic [MFP_SELW-1:0] target);
    wr_hit = wr && (sel == target);
  endfunction : wr_hit

  // Drive enable: push-pull bits always drive, open-drain bits only pull low
  function automatic logic [MFP_DW-1:0] drive_en(input logic [MFP_DW-1:0] latch,
                                                 input logic [MFP_DW-1:0] push_pull);
    drive_en = push_pull | ~latch;
  endfunction : drive_en

  ////////////////////////////////////////////////////////////////////////////
  // Direction-controlled port slices
  assign wake_if.wr_data_stb = wr_hit(cpu_wr, cpu_sel, SEL_WAKE_DATA);
  assign wake_if.wr_dir_stb  = wr_hit(cpu_wr, cpu_sel, SEL_WAKE_DIR);
  assign wake_if.wr_ien_stb  = wr_hit(cpu_wr, cpu_sel, SEL_WAKE_IEN);
  assign wake_if.wr_val      = cpu_wdata;
  assign wake_if.pin_in      = wake_pin_in;

  // Analog-only port slice controls
  assign ana_if.wr_data_stb  = wr_hit(cpu_wr, cpu_sel, SEL_ANA_DATA);
  assign ana_if.wr_dir_stb   = wr_hit(cpu_wr, cpu_sel, SEL_ANA_DIR);
  assign ana_if.wr_ien_stb   = wr_hit(cpu_wr, cpu_sel, SEL_ANA_IEN);
  assign ana_if.wr_val       = cpu_wdata;
  assign ana_if.pin_in       = ana_pin_in;

  mfp_dir_port #(.W(MFP_DW)) u_wake (
    .clk_sys (clk_sys),
    .rst     (rst),
    .bus     (wake_if.port)
  );

  mfp_dir_port #(.W(MFP_DW)) u_ana (
    .clk_sys (clk_sys),
    .rst     (rst),
    .bus     (ana_if.port)
  );

  ////////////////////////////////////////////////////////////////////////////
  // High-current port: next latch and sink-only driver
  always_comb begin
    nxt_hc_port_a_latch = wr_hit(cpu_wr, cpu_sel, SEL_HC_LATCH) ? cpu_wdata : hc_port_a_latch_ff;
    nxt_hc_out          = nxt_hc_port_a_latch;
    nxt_hc_oe           = ~nxt_hc_port_a_latch;
  end

  // High-current port registers, reset loads all ones
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hc_port_a_latch_ff <= HC_LATCH_RST;
      hc_out_ff          <= HC_LATCH_RST;
      hc_oe_ff           <= ~HC_LATCH_RST;
    end else begin
      hc_port_a_latch_ff <= nxt_hc_port_a_latch;
      hc_out_ff          <= nxt_hc_out;
      hc_oe_ff           <= nxt_hc_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial port: next latch, drive select and driver
  always_comb begin
    nxt_serial_port_latch        = wr_hit(cpu_wr, cpu_sel, SEL_SER_LATCH) ? cpu_wdata : serial_port_latch_ff;
    nxt_serial_port_drive_select = wr_hit(cpu_wr, cpu_sel, SEL_SER_DRIVE) ? cpu_wdata
                                                                          : serial_port_drive_select_ff;
    nxt_ser_out                  = nxt_serial_port_latch;
    nxt_ser_oe                   = drive_en(nxt_serial_port_latch, nxt_serial_port_drive_select);
  end

  // Serial port registers, reset selects open drain
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      serial_port_latch_ff        <= SER_LATCH_RST;
      serial_port_drive_select_ff <= SER_DRIVE_RST;
      ser_out_ff                  <= SER_LATCH_RST;
      ser_oe_ff                   <= drive_en(SER_LATCH_RST, SER_DRIVE_RST);
    end else begin
      serial_port_latch_ff        <= nxt_serial_port_latch;
      serial_port_drive_select_ff <= nxt_serial_port_drive_select;
      ser_out_ff                  <= nxt_ser_out;
      ser_oe_ff                   <= nxt_ser_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I2C port: next latch and sink-only driver
  always_comb begin
    nxt_i2c_port_latch = wr_hit(cpu_wr, cpu_sel, SEL_I2C_LATCH) ? cpu_wdata[MFP_I2CW-1:0] : i2c_port_latch_ff;
    nxt_i2c_out        = nxt_i2c_port_latch;
    nxt_i2c_oe         = ~nxt_i2c_port_latch;
  end

  // I2C port registers, reset loads all ones
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      i2c_port_latch_ff <= I2C_LATCH_RST;
      i2c_out_ff        <= I2C_LATCH_RST;
      i2c_oe_ff         <= ~I2C_LATCH_RST;
    end else begin
      i2c_port_latch_ff <= nxt_i2c_port_latch;
      i2c_out_ff        <= nxt_i2c_out;
      i2c_oe_ff         <= nxt_i2c_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key wakeup select: plain register, no gating by direction
  always_comb begin
    nxt_key_sel = wr_hit(cpu_wr, cpu_sel, SEL_WAKE_KEY) ? cpu_wdata : key_sel_ff;
  end

  // Key wakeup select update, reset clears every select
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      key_sel_ff <= KEY_SEL_RST;
    end else begin
      key_sel_ff <= nxt_key_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data sampled in the read strobe cycle
  always_comb begin
    nxt_rdata = rdata_ff;
    if (cpu_rd) begin
      case (cpu_sel)
        SEL_HC_LATCH:  nxt_rdata = hc_port_a_latch_ff;
        SEL_HC_PIN:    nxt_rdata = hc_pin_in;
        SEL_SER_LATCH: nxt_rdata = serial_port_latch_ff;
        SEL_SER_DRIVE: nxt_rdata = serial_port_drive_select_ff;
        SEL_SER_PIN:   nxt_rdata = ser_pin_in;
        SEL_I2C_LATCH: nxt_rdata = {UPPER_ZERO[MFP_DW-1:MFP_I2CW], i2c_port_latch_ff};
        SEL_I2C_PIN:   nxt_rdata = {UPPER_ZERO[MFP_DW-1:MFP_I2CW], i2c_pin_in};
        SEL_WAKE_DATA: nxt_rdata = wake_if.rd_val;
        SEL_WAKE_DIR:  nxt_rdata = wake_if.dir;
        SEL_WAKE_IEN:  nxt_rdata = wake_if.ien;
        SEL_WAKE_KEY:  nxt_rdata = key_sel_ff;
        SEL_ANA_DATA:  nxt_rdata = ana_if.rd_val;
        SEL_ANA_DIR:   nxt_rdata = ana_if.dir;
        SEL_ANA_IEN:   nxt_rdata = ana_if.ien;
        default:       nxt_rdata = RDATA_RST;
      endcase
    end
  end

  // Read data register, holds until the next read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_ff <= RDATA_RST;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign cpu_rdata         = rdata_ff;

  // Fixed-function port pins
  assign hc_pin_out        = hc_out_ff;
  assign hc_pin_oe         = hc_oe_ff;
  assign ser_pin_out       = ser_out_ff;
  assign ser_pin_oe        = ser_oe_ff;
  assign i2c_pin_out       = i2c_out_ff;
  assign i2c_pin_oe        = i2c_oe_ff;

  // Direction-controlled port pins and enables
  assign wake_pin_out      = wake_if.pin_out;
  assign wake_pin_oe       = wake_if.pin_oe;
  assign wake_digital_en   = wake_if.ien;
  assign key_wakeup_select = key_sel_ff;
  assign ana_pin_out       = ana_if.pin_out;
  assign ana_pin_oe        = ana_if.pin_oe;
  assign ana_digital_en    = ana_if.ien;

endmodule : mfp_io_ports

// [verif/mfp_pin_model.sv]
// Board-side model resolving port pin levels
`timescale 1ns/1ps
module mfp_pin_model #(
  parameter int unsigned W = 8
) (
  // Device side
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  // Board side
  input  wire logic [W-1:0] ext_lvl,
  output logic      [W-1:0] pin_lvl
);
  // Driven bits follow the device, released bits the board
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : mfp_pin_model

// [verif/mfp_io_ports_sva.sv]
// Assertions on the port block's top-level ports
`timescale 1ns/1ps
module mfp_io_ports_sva
  import mfp_pkg::*;
(
  // Clock, reset and CPU port
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic                cpu_wr,
  input wire logic                cpu_rd,
  input wire logic [MFP_SELW-1:0] cpu_sel,
  input wire logic [MFP_DW-1:0]   cpu_wdata,
  input wire logic [MFP_DW-1:0]   cpu_rdata,
  // Pins
  input wire logic [MFP_DW-1:0]   hc_pin_in,
  input wire logic [MFP_DW-1:0]   hc_pin_out,
  input wire logic [MFP_DW-1:0]   hc_pin_oe,
  input wire logic [MFP_DW-1:0]   ser_pin_out,
  input wire logic [MFP_DW-1:0]   ser_pin_oe,
  input wire logic [MFP_I2CW-1:0] i2c_pin_out,
  input wire logic [MFP_DW-1:0]   wake_pin_in,
  input wire logic [MFP_DW-1:0]   wake_pin_out,
  input wire logic [MFP_DW-1:0]   wake_pin_oe,
  input wire logic [MFP_DW-1:0]   wake_digital_en,
  input wire logic [MFP_DW-1:0]   ana_pin_in,
  input wire logic [MFP_DW-1:0]   ana_pin_out,
  input wire logic [MFP_DW-1:0]   ana_pin_oe,
  input wire logic [MFP_DW-1:0]   ana_digital_en,
  input wire logic [MFP_DW-1:0]   key_wakeup_select
);
  // One clock domain
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  a_hc_ser_reset: assert property ($fell(rst) |-> hc_pin_out == 8'hff && ser_pin_out == 8'hff && ser_pin_oe == 8'h00)
    else $error("hc or serial reset state wrong");
  a_wake_i2c_reset: assert property ($fell(rst) |-> i2c_pin_out == 5'h1f && wake_pin_oe == 8'h00 && wake_pin_out == 8'h00 && wake_digital_en == 8'hff)
    else $error("i2c or wake reset state wrong");
  a_ana_reset: assert property ($fell(rst) |-> ana_pin_oe == 8'h00 && ana_pin_out == 8'h00 && ana_digital_en == 8'hff)
    else $error("analog reset state wrong");
  a_hc_write_next: assert property (cpu_wr && cpu_sel == SEL_HC_LATCH |=> hc_pin_out == $past(cpu_wdata) && hc_pin_oe == ~hc_pin_out)
    else $error("hc latch write not applied");
  a_ser_drive_mode: assert property (cpu_wr && cpu_sel == SEL_SER_DRIVE |=> ser_pin_oe == ($past(cpu_wdata) | ~ser_pin_out))
    else $error("serial drive mode wrong");
  a_hc_pin_read: assert property (cpu_rd && cpu_sel == SEL_HC_PIN |=> cpu_rdata == $past(hc_pin_in))
    else $error("hc pin read wrong");
  a_i2c_upper_bits: assert property (cpu_rd && (cpu_sel == SEL_I2C_PIN || cpu_sel == SEL_I2C_LATCH) |=> cpu_rdata[7:5] == 3'h0)
    else $error("i2c upper bits not zero");
  a_wake_data_read: assert property (cpu_rd && cpu_sel == SEL_WAKE_DATA |=> cpu_rdata == (($past(wake_pin_oe) & $past(wake_pin_out))
    | (~$past(wake_pin_oe) & $past(wake_digital_en) & $past(wake_pin_in))))
    else $error("wake data read wrong");
  a_ana_data_read: assert property (cpu_rd && cpu_sel == SEL_ANA_DATA |=> cpu_rdata == (($past(ana_pin_oe) & $past(ana_pin_out))
    | (~$past(ana_pin_oe) & $past(ana_digital_en) & $past(ana_pin_in))))
    else $error("analog data read wrong");
  a_wake_dir_write: assert property (cpu_wr && cpu_sel == SEL_WAKE_DIR |=> wake_pin_oe == $past(cpu_wdata))
    else $error("wake direction not applied");
  a_key_sel_write: assert property (cpu_wr && cpu_sel == SEL_WAKE_KEY |=> key_wakeup_select == $past(cpu_wdata))
    else $error("key wakeup select write not applied");
  a_ana_dir_write: assert property (cpu_wr && cpu_sel == SEL_ANA_DIR |=> ana_pin_oe == $past(cpu_wdata))
    else $error("analog direction not applied");
endmodule : mfp_io_ports_sva
bind mfp_io_ports mfp_io_ports_sva mfp_io_ports_sva_inst (.clk_sys, .rst, .cpu_wr, .cpu_rd, .cpu_sel, .cpu_wdata,
  .cpu_rdata, .hc_pin_in, .hc_pin_out, .hc_pin_oe, .ser_pin_out, .ser_pin_oe, .i2c_pin_out, .wake_pin_in,
  .wake_pin_out, .wake_pin_oe, .wake_digital_en, .ana_pin_in, .ana_pin_out, .ana_pin_oe, .ana_digital_en,
  .key_wakeup_select);

// [verif/mfp_io_ports_bench.sv]
// Self-checking bench for the multi-function port block
`timescale 1ns/1ps
module mfp_io_ports_bench;
  import mfp_pkg::*;
  logic                clk_sys = 1'b0, rst = 1'b1, cpu_wr = 1'b0, cpu_rd = 1'b0, rd_d = 1'b0;
  logic [MFP_SELW-1:0] cpu_sel = 4'h0, base;
  logic [MFP_DW-1:0]   cpu_wdata = 8'h00, cpu_rdata, d, s, g, v, e;
  logic [MFP_DW-1:0]   hc_pin_in, hc_pin_out, hc_pin_oe, ser_pin_in, ser_pin_out, ser_pin_oe;
  logic [MFP_DW-1:0]   wake_pin_in, wake_pin_out, wake_pin_oe, wake_digital_en, key_wakeup_select;
  logic [MFP_DW-1:0]   ana_pin_in, ana_pin_out, ana_pin_oe, ana_digital_en;
  logic [MFP_I2CW-1:0] i2c_pin_in, i2c_pin_out, i2c_pin_oe, i2c_ext = 5'h16;
  logic [MFP_DW-1:0]   hc_ext = 8'ha5, ser_ext = 8'h3c, wake_ext = 8'h69, ana_ext = 8'hc3;
  logic [MFP_DW-1:0]   exp_q [$];
  logic [MFP_DW-1:0]   rst_exp [16] = '{8'hff, 8'ha5, 8'hff, 8'h00, 8'h3c, 8'h1f, 8'h16, 8'h69,
                                        8'h00, 8'hff, 8'h00, 8'hc3, 8'h00, 8'hff, 8'h00, 8'h00};
  integer              seed = 38375;
  int                  err_count = 0, checked = 0;
  ////////////////////////////////////////////////////////////////
  // Device and board-side pin models
  mfp_io_ports mfp_io_ports_inst (.clk_sys, .rst, .cpu_wr, .cpu_rd, .cpu_sel, .cpu_wdata, .cpu_rdata,
    .hc_pin_in, .hc_pin_out, .hc_pin_oe, .ser_pin_in, .ser_pin_out, .ser_pin_oe, .i2c_pin_in, .i2c_pin_out,
    .i2c_pin_oe, .wake_pin_in, .wake_pin_out, .wake_pin_oe, .wake_digital_en, .key_wakeup_select,
    .ana_pin_in, .ana_pin_out, .ana_pin_oe, .ana_digital_en);
  mfp_pin_model #(.W(8)) hc_pin_model (.pin_out(hc_pin_out), .pin_oe(hc_pin_oe), .ext_lvl(hc_ext), .pin_lvl(hc_pin_in));
  mfp_pin_model #(.W(8)) ser_pin_model (.pin_out(ser_pin_out), .pin_oe(ser_pin_oe), .ext_lvl(ser_ext),
    .pin_lvl(ser_pin_in));
  mfp_pin_model #(.W(5)) i2c_pin_model (.pin_out(i2c_pin_out), .pin_oe(i2c_pin_oe), .ext_lvl(i2c_ext),
    .pin_lvl(i2c_pin_in));
  mfp_pin_model #(.W(8)) wake_pin_model (.pin_out(wake_pin_out), .pin_oe(wake_pin_oe), .ext_lvl(wake_ext),
    .pin_lvl(wake_pin_in));
  mfp_pin_model #(.W(8)) ana_pin_model (.pin_out(ana_pin_out), .pin_oe(ana_pin_oe), .ext_lvl(ana_ext),
    .pin_lvl(ana_pin_in));
  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #25 clk_sys = ~clk_sys;
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count = err_count + 1;
    summarize();
  end
  // CPU cycles; strobes set once per call, never lowered in the same step
  task automatic wr(input logic [MFP_SELW-1:0] sel, input logic [MFP_DW-1:0] dat);
    cpu_wr = 1'b1;
    cpu_rd = 1'b0;
    cpu_sel = sel;
    cpu_wdata = dat;
    @(posedge clk_sys);
    #1;
  endtask : wr
  task automatic rd(input logic [MFP_SELW-1:0] sel, input logic [MFP_DW-1:0] want);
    exp_q.push_back(want);
    cpu_wr = 1'b0;
    cpu_rd = 1'b1;
    cpu_sel = sel;
    @(posedge clk_sys);
    #1;
  endtask : rd
  task automatic idle;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic summarize;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // Read monitor: oldest note against read data one cycle on
  always @(posedge clk_sys) begin
    if (rd_d) begin
      checked = checked + 1;
      if (cpu_rdata !== exp_q[0]) begin
        err_count = err_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, cpu_rdata, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
    rd_d <= cpu_rd & ~rst;
  end
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], rst_exp[i]);
    end
    wr(4'he, 8'h55);
    rd(4'he, 8'h00);
    repeat (24) begin
      d = 8'($random(seed));
      s = 8'($random(seed));
      g = 8'($random(seed));
      {hc_ext, ser_ext, wake_ext, ana_ext} = $random(seed);
      i2c_ext = 5'($random(seed));
      wr(SEL_HC_LATCH, d);
      rd(SEL_HC_PIN, d & hc_ext);
      rd(SEL_HC_LATCH, d);
      wr(SEL_SER_LATCH, d);
      wr(SEL_SER_DRIVE, s);
      rd(SEL_SER_PIN, d & (s | ser_ext));
      wr(SEL_I2C_LATCH, d);
      rd(SEL_I2C_PIN, {3'h0, d[4:0] & i2c_ext});
      for (int p = 0; p < 2; p++) begin
        base = (p == 1) ? SEL_ANA_DATA : SEL_WAKE_DATA;
        e = (p == 1) ? ana_ext : wake_ext;
        v = (s & d) | (~s & g & e);
        wr(base, d);
        wr(base + 4'h1, s);
        wr(base + 4'h2, g);
        rd(base, v);
        wr(base, v);
        wr(base + 4'h1, 8'hff);
        rd(base, v);
      end
    end
    wr(SEL_SER_LATCH, 8'hff);
    wr(SEL_SER_DRIVE, 8'h00);
    rd(SEL_SER_PIN, ser_ext);
    wr(SEL_WAKE_DIR, 8'h00);
    wr(SEL_WAKE_KEY, 8'h0f);
    rd(SEL_WAKE_KEY, 8'h0f);
    wr(SEL_WAKE_IEN, 8'h00);
    rd(SEL_WAKE_DATA, 8'h00);
    wr(SEL_ANA_DIR, 8'h00);
    wr(SEL_ANA_IEN, 8'h00);
    rd(SEL_ANA_DATA, 8'h00);
    rst = 1'b1;
    wr(SEL_HC_LATCH, 8'h00);
    rst = 1'b0;
    rd(SEL_HC_LATCH, 8'hff);
    rd(SEL_I2C_LATCH, 8'h1f);
    idle();
    idle();
    summarize();
  end
endmodule : mfp_io_ports_bench
